// File: design/clkgen_pkg.sv
// Package for the clock divider and main PLL control block.
// Holds register offsets, field positions, reset values and the
// structs that carry the clock ticks and the PLL control pins.
package clkgen_pkg;

    // Register offsets on the plain register port (byte addresses).
    localparam logic [7:0] OFF_DIV0 = 8'h14;
    localparam logic [7:0] OFF_DIV1 = 8'h18;
    localparam logic [7:0] OFF_PLL = 8'h20;
    localparam logic [7:0] OFF_RATIO = 8'h24;

    // Reset values.
    localparam logic [31:0] RST_DIV0 = 32'h0000_0000;
    localparam logic [31:0] RST_DIV1 = 32'h0000_0000;
    localparam logic [31:0] RST_PLL = 32'h0001_4035;

    // Writable bits; reserved bits always read as zero.
    localparam logic [31:0] MASK_DIV0 = 32'h00FF_FFCF;
    localparam logic [31:0] MASK_DIV1 = 32'h00FF_0000;
    localparam logic [31:0] MASK_PLL = 32'h0007_FFFF;

    // Field positions of clock_divider_numbers_0.
    localparam int USB_DIV_LSB = 20;
    localparam int UART_DIV_LSB = 16;
    localparam int AUDIO_DIV_LSB = 8;
    localparam int APB_DIV_LSB = 6;
    localparam int HCLK_DIV_LSB = 0;
    // Field position of clock_divider_numbers_1.
    localparam int ADC_DIV_LSB = 16;
    // Field positions of main_pll_control.
    localparam int PLL_GATE_BIT = 18;
    localparam int PLL_BYPASS_BIT = 17;
    localparam int PLL_PDOWN_BIT = 16;
    localparam int PLL_POST_LSB = 14;
    localparam int PLL_REF_LSB = 9;
    localparam int PLL_FB_LSB = 0;
    // Field positions of the read-only ratio status word.
    localparam int RATIO_IN_LSB = 0;
    localparam int RATIO_FB_LSB = 8;
    localparam int RATIO_OUT_LSB = 20;

    // Fixed halving ahead of the system bus divider.
    localparam logic [1:0] HCLK_PRESCALE = 2'h2;
    // Ratio arithmetic: twice the sum of the field value and two.
    localparam int RATIO_OFFSET = 2;
    localparam int RATIO_SCALE = 2;

    // One-cycle ticks marking the edges of each source clock.
    typedef struct packed {
        logic usb;
        logic uart;
        logic audio;
        logic cpu;
        logic hclk;
        logic adc;
    } clock_ticks_t;

    // Pins of the PLL macro that the control register drives.
    typedef struct packed {
        logic out_gate;
        logic bypass;
        logic power_down;
        logic [1:0] post_div;
        logic [4:0] ref_div;
        logic [8:0] fb_div;
    } pll_pins_t;

endpackage

// File: design/tick_divider.sv
// Divides a stream of source ticks by (divisor + 1) times a prescale.
// Assumes src_tick is a one-cycle pulse synchronous to clock.
`timescale 1ns/1ps
module tick_divider (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic src_tick,
    input wire logic [7:0] divisor,
    input wire logic [1:0] prescale,
    output logic out_tick
);
    logic [9:0] count;
    logic [9:0] limit;

    // Last count of an output period, one less than its ticks; a divisor of zero with a prescale of one passes every tick.
    assign limit = 10'((divisor + 9'h001) * prescale) - 10'h001;

    // The >= compare lets a shrunken divisor take effect at once
    // instead of waiting for the counter to wrap.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count <= 10'h000;
            out_tick <= 1'b0;
        end else if (src_tick) begin
            if (count >= limit) begin
                count <= 10'h000;
                out_tick <= 1'b1;
            end else begin
                count <= count + 10'h001;
                out_tick <= 1'b0;
            end
        end else begin
            out_tick <= 1'b0;
        end
    end
endmodule

// File: design/pll_ratio_decode.sv
// Decodes the PLL divider fields into the effective divide ratios.
// Pure combinational; the caller registers the results if needed.
`timescale 1ns/1ps
module pll_ratio_decode (
    input wire logic [4:0] ref_div,
    input wire logic [8:0] fb_div,
    input wire logic [1:0] post_div,
    output logic [6:0] in_ratio,
    output logic [10:0] fb_ratio,
    output logic [2:0] out_ratio
);
    // Twice the sum of the field value and two, shared by both dividers.
    function automatic logic [10:0] twice_plus_two(input logic [8:0] v);
        twice_plus_two = 11'((11'(v) + 11'(clkgen_pkg::RATIO_OFFSET))
            * 11'(clkgen_pkg::RATIO_SCALE));
    endfunction

    assign in_ratio = 7'(twice_plus_two({4'h0, ref_div}));
    assign fb_ratio = twice_plus_two(fb_div);

    // Codes 01 and 10 both halve the output.
    always_comb begin
        unique case (post_div)
            2'h0: out_ratio = 3'h1;
            2'h1: out_ratio = 3'h2;
            2'h2: out_ratio = 3'h2;
            2'h3: out_ratio = 3'h4;
        endcase
    end
endmodule

// File: design/clock_divider_pll_control.sv
// Clock divider and main PLL control block: two divider registers,
// the PLL control register and a read-only ratio status word.
// Assumes source clock edges arrive as one-cycle ticks synchronous to
// clock, and that the PLL macro sits outside with its raw output fed in.
`timescale 1ns/1ps
module clock_divider_pll_control (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire clkgen_pkg::clock_ticks_t src_ticks,
    output clkgen_pkg::clock_ticks_t div_ticks,
    input wire logic xtal_clk,
    input wire logic pll_raw_clk,
    output logic pll_ref_clk,
    output logic pll_clk_out,
    output clkgen_pkg::pll_pins_t pll_pins
);
    // Register storage.
    logic [31:0] clock_divider_numbers_0;
    logic [31:0] clock_divider_numbers_1;
    logic [31:0] main_pll_control;
    logic [31:0] next_rdata;

    // Divider fields, the narrower ones widened to the divider's eight bits.
    logic [7:0] usb_divisor;
    logic [7:0] uart_divisor;
    logic [7:0] audio_divisor;
    logic [7:0] peripheral_bus_divisor;
    logic [7:0] system_bus_divisor;
    logic [7:0] adc_divisor;

    // Decoded PLL ratios for the status word.
    logic [6:0] in_ratio;
    logic [10:0] fb_ratio;
    logic [2:0] out_ratio;
    logic [31:0] ratio_status;

    // Address decode, shared by the write and read paths.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Clock divider number register 0, software writable.
    // Reserved bits are masked so they always read back as zero.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clock_divider_numbers_0 <= clkgen_pkg::RST_DIV0;
        end else if (reg_write && hit(reg_addr, clkgen_pkg::OFF_DIV0)) begin
            clock_divider_numbers_0 <= reg_wdata & clkgen_pkg::MASK_DIV0;
        end
    end

    // Clock divider number register 1, holding only the ADC field.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clock_divider_numbers_1 <= clkgen_pkg::RST_DIV1;
        end else if (reg_write && hit(reg_addr, clkgen_pkg::OFF_DIV1)) begin
            clock_divider_numbers_1 <= reg_wdata & clkgen_pkg::MASK_DIV1;
        end
    end

    // Main PLL control register.
    // Its reset value sets the power-down bit (bit 16), so the PLL comes
    // up powered down until software clears that bit.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            main_pll_control <= clkgen_pkg::RST_PLL;
        end else if (reg_write && hit(reg_addr, clkgen_pkg::OFF_PLL)) begin
            main_pll_control <= reg_wdata & clkgen_pkg::MASK_PLL;
        end
    end

    // Field extraction from clock_divider_numbers_0 and _1.
    assign usb_divisor =
        {4'h0, clock_divider_numbers_0[clkgen_pkg::USB_DIV_LSB +: 4]};
    assign uart_divisor =
        {4'h0, clock_divider_numbers_0[clkgen_pkg::UART_DIV_LSB +: 4]};
    assign audio_divisor =
        clock_divider_numbers_0[clkgen_pkg::AUDIO_DIV_LSB +: 8];
    assign peripheral_bus_divisor =
        {6'h00, clock_divider_numbers_0[clkgen_pkg::APB_DIV_LSB +: 2]};
    assign system_bus_divisor =
        {4'h0, clock_divider_numbers_0[clkgen_pkg::HCLK_DIV_LSB +: 4]};
    assign adc_divisor =
        clock_divider_numbers_1[clkgen_pkg::ADC_DIV_LSB +: 8];

    // USB clock from its selected source.
    tick_divider usb_div (
        .clock(clock),
        .rst_n(rst_n),
        .src_tick(src_ticks.usb),
        .divisor(usb_divisor),
        .prescale(2'h1),
        .out_tick(div_ticks.usb)
    );

    // UART clock from its selected source.
    tick_divider uart_div (
        .clock(clock),
        .rst_n(rst_n),
        .src_tick(src_ticks.uart),
        .divisor(uart_divisor),
        .prescale(2'h1),
        .out_tick(div_ticks.uart)
    );

    // Audio-process clock from its selected source.
    tick_divider audio_div (
        .clock(clock),
        .rst_n(rst_n),
        .src_tick(src_ticks.audio),
        .divisor(audio_divisor),
        .prescale(2'h1),
        .out_tick(div_ticks.audio)
    );

    // Peripheral bus clock always follows the CPU clock, never a
    // selectable source, so bus timing stays tied to the processor.
    tick_divider apb_div (
        .clock(clock),
        .rst_n(rst_n),
        .src_tick(src_ticks.cpu),
        .divisor(peripheral_bus_divisor),
        .prescale(2'h1),
        .out_tick(div_ticks.cpu)
    );

    // System bus clock carries a fixed halving ahead of its divider.
    // Even with a zero field it never runs at the full source rate.
    tick_divider hclk_div (
        .clock(clock),
        .rst_n(rst_n),
        .src_tick(src_ticks.hclk),
        .divisor(system_bus_divisor),
        .prescale(clkgen_pkg::HCLK_PRESCALE),
        .out_tick(div_ticks.hclk)
    );

    // ADC engine clock from its selected source.
    tick_divider adc_div (
        .clock(clock),
        .rst_n(rst_n),
        .src_tick(src_ticks.adc),
        .divisor(adc_divisor),
        .prescale(2'h1),
        .out_tick(div_ticks.adc)
    );

    // PLL control pins come straight from register bits, so a write
    // reaches the macro one cycle after the strobe.
    assign pll_pins.out_gate = main_pll_control[clkgen_pkg::PLL_GATE_BIT];
    assign pll_pins.bypass = main_pll_control[clkgen_pkg::PLL_BYPASS_BIT];
    assign pll_pins.power_down =
        main_pll_control[clkgen_pkg::PLL_PDOWN_BIT];
    assign pll_pins.post_div =
        main_pll_control[clkgen_pkg::PLL_POST_LSB +: 2];
    assign pll_pins.ref_div =
        main_pll_control[clkgen_pkg::PLL_REF_LSB +: 5];
    assign pll_pins.fb_div =
        main_pll_control[clkgen_pkg::PLL_FB_LSB +: 9];

    // The reference is a clock, so it is wired through without any
    // flip-flop; sampling it on clock would alias it.
    assign pll_ref_clk = xtal_clk;

    // Output selection: the gate wins over bypass, so a gated PLL
    // stays low even while bypassed. This path is glitch-prone when
    // the bits change; software should gate before switching bypass.
    always_comb begin
        if (pll_pins.out_gate) begin
            pll_clk_out = 1'b0;
        end else if (pll_pins.bypass) begin
            pll_clk_out = xtal_clk;
        end else begin
            pll_clk_out = pll_raw_clk;
        end
    end

    // Effective ratios, shown to software for bring-up checks.
    pll_ratio_decode ratio_dec (
        .ref_div(pll_pins.ref_div),
        .fb_div(pll_pins.fb_div),
        .post_div(pll_pins.post_div),
        .in_ratio(in_ratio),
        .fb_ratio(fb_ratio),
        .out_ratio(out_ratio)
    );

    // Packs the ratios into the read-only status word.
    always_comb begin
        ratio_status = 32'h0000_0000;
        ratio_status[clkgen_pkg::RATIO_IN_LSB +: 7] = in_ratio;
        ratio_status[clkgen_pkg::RATIO_FB_LSB +: 11] = fb_ratio;
        ratio_status[clkgen_pkg::RATIO_OUT_LSB +: 3] = out_ratio;
    end

    // Read multiplexer; unmapped offsets answer with zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit(reg_addr, clkgen_pkg::OFF_DIV0)) begin
            next_rdata = clock_divider_numbers_0;
        end else if (hit(reg_addr, clkgen_pkg::OFF_DIV1)) begin
            next_rdata = clock_divider_numbers_1;
        end else if (hit(reg_addr, clkgen_pkg::OFF_PLL)) begin
            next_rdata = main_pll_control;
        end else if (hit(reg_addr, clkgen_pkg::OFF_RATIO)) begin
            next_rdata = ratio_status;
        end
    end

    // Read data stand for exactly the cycle after the strobe and are
    // zero otherwise, which keeps a shared read bus easy to OR.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

// File: dv/clkgen_asserts.sv
// Checker for the clock divider and PLL control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module clkgen_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic xtal_clk,
    input wire logic pll_raw_clk,
    input wire logic pll_ref_clk,
    input wire logic pll_clk_out,
    input wire clkgen_pkg::clock_ticks_t src_ticks,
    input wire clkgen_pkg::clock_ticks_t div_ticks,
    input wire clkgen_pkg::pll_pins_t pll_pins
);
    // All checks share one clock and are muted while reset is low.
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_ref; pll_ref_clk == xtal_clk; endproperty
    property p_gate; pll_pins.out_gate |-> !pll_clk_out; endproperty
    property p_byp;
        !pll_pins.out_gate && pll_pins.bypass |-> pll_clk_out == xtal_clk;
    endproperty
    property p_run;
        !pll_pins.out_gate && !pll_pins.bypass |-> pll_clk_out == pll_raw_clk;
    endproperty
    property p_pll_rst;
        $rose(rst_n) |-> pll_pins == clkgen_pkg::RST_PLL[18:0];
    endproperty
    property p_div_rst; $rose(rst_n) |-> div_ticks == '0; endproperty
    property p_wr;
        reg_write && reg_addr == clkgen_pkg::OFF_PLL
            |=> pll_pins == $past(reg_wdata[18:0]);
    endproperty
    property p_hold;
        !(reg_write && reg_addr == clkgen_pkg::OFF_PLL) |=> $stable(pll_pins);
    endproperty
    // A divided tick can only follow a counted source tick.
    property p_usb; div_ticks.usb |-> $past(src_ticks.usb); endproperty
    property p_adc; div_ticks.adc |-> $past(src_ticks.adc); endproperty
    // The fixed halving means two system bus ticks never touch.
    property p_hclk; div_ticks.hclk |=> !div_ticks.hclk; endproperty

    a_ref: assert property (p_ref) else $error("ref clock differs");
    a_gate: assert property (p_gate) else $error("gated out high");
    a_byp: assert property (p_byp) else $error("bypass wrong");
    a_run: assert property (p_run) else $error("raw not passed");
    a_pll_rst: assert property (p_pll_rst) else $error("pins reset");
    a_div_rst: assert property (p_div_rst) else $error("ticks reset");
    a_wr: assert property (p_wr) else $error("pins not set");
    a_hold: assert property (p_hold) else $error("pins moved");
    a_usb: assert property (p_usb) else $error("usb tick");
    a_adc: assert property (p_adc) else $error("adc tick");
    a_hclk: assert property (p_hclk) else $error("hclk tick");
    c_wr: cover property (reg_write && reg_addr == clkgen_pkg::OFF_PLL);
    c_hclk: cover property (div_ticks.hclk);
    c_gate: cover property (pll_pins.out_gate);
endmodule
bind clock_divider_pll_control clkgen_asserts chk_u (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .xtal_clk(xtal_clk),
    .pll_raw_clk(pll_raw_clk), .pll_ref_clk(pll_ref_clk),
    .pll_clk_out(pll_clk_out), .src_ticks(src_ticks),
    .div_ticks(div_ticks), .pll_pins(pll_pins)
);

// File: dv/tb_top.sv
// Self-checking bench for the clock divider and PLL control block.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic clock, rst_n, reg_write, reg_read, xtal_clk, pll_raw_clk;
    logic pll_ref_clk, pll_clk_out, tick_chk;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, m_div0, m_div1, m_pll, wv;
    logic [15:0] seed;
    logic [5:0] exp_ticks;
    clkgen_pkg::clock_ticks_t src_ticks, div_ticks;
    clkgen_pkg::pll_pins_t pll_pins;
    int err_count, cmp_count, cnt[6];

    clock_divider_pll_control dut_u (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .src_ticks(src_ticks),
        .div_ticks(div_ticks), .xtal_clk(xtal_clk),
        .pll_raw_clk(pll_raw_clk), .pll_ref_clk(pll_ref_clk),
        .pll_clk_out(pll_clk_out), .pll_pins(pll_pins));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Sixteen-bit LFSR stepped many times so each word looks fresh.
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) begin
            seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        end
        return {seed, seed ^ 16'hA5A5};
    endfunction

    // Source ticks needed per divided tick, from the model's registers.
    function automatic int limit(int i);
        case (i)
            5: return m_div0[23:20] + 1;
            4: return m_div0[19:16] + 1;
            3: return m_div0[15:8] + 1;
            2: return m_div0[7:6] + 1;
            1: return 2 * (m_div0[3:0] + 1);
            default: return m_div1[23:16] + 1;
        endcase
    endfunction

    // Expected ratio status word for a given PLL control value.
    function automatic logic [31:0] rat(logic [31:0] p);
        logic [31:0] no;
        no = (p[15:14] == 2'h0) ? 1 : (p[15:14] == 2'h3) ? 4 : 2;
        return 32'(2 * (p[13:9] + 2)) | (32'(2 * (p[8:0] + 2)) << 8)
            | (no << 20);
    endfunction

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // Read data is looked at in the cycle right after the strobe, and
    // must drop back to zero one cycle later so a shared bus stays clean.
    task automatic rdchk(string name, logic [7:0] a, logic [31:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(name, reg_rdata, e);
        @(posedge clock);
        #1;
        chk("rdata_idle", reg_rdata, 32'h0);
    endtask

    task automatic check_reset();
        chk("pins", pll_pins, clkgen_pkg::RST_PLL[18:0]);
        rdchk("div0", clkgen_pkg::OFF_DIV0, 32'h0);
        rdchk("div1", clkgen_pkg::OFF_DIV1, 32'h0);
        rdchk("pll", clkgen_pkg::OFF_PLL, clkgen_pkg::RST_PLL);
        rdchk("ratio", clkgen_pkg::OFF_RATIO, rat(clkgen_pkg::RST_PLL));
    endtask

    // Random source ticks; divisors stay fixed while they run.
    task automatic tick_run(int n);
        tick_chk = 1'b1;
        repeat (n) begin
            @(posedge clock);
            src_ticks <= 6'(rnd());
        end
        @(posedge clock);
        src_ticks <= '0;
        @(posedge clock);
        tick_chk = 1'b0;
    endtask

    // Divider model; counts persist across divisor changes, as in hardware.
    always @(posedge clock) begin
        for (int i = 0; i < 6; i++) begin
            exp_ticks[i] = 1'b0;
            if (!rst_n) begin
                cnt[i] = 0;
            end else if (src_ticks[i]) begin
                cnt[i] = cnt[i] + 1;
                exp_ticks[i] = (cnt[i] >= limit(i));
                if (exp_ticks[i]) begin
                    cnt[i] = 0;
                end
            end
        end
    end

    always @(negedge clock) begin
        if (tick_chk && rst_n) begin
            chk("div_ticks", div_ticks, exp_ticks);
        end
    end

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 1500 cycles the tests need.
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        print_verdict();
    end

    initial begin
        {rst_n, reg_write, reg_read, xtal_clk, pll_raw_clk, tick_chk} = '0;
        {reg_addr, reg_wdata, src_ticks} = '0;
        {err_count, cmp_count} = '0;
        seed = 16'hA62C;
        m_div0 = '0;
        m_div1 = '0;
        m_pll = clkgen_pkg::RST_PLL;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check_reset();
        tick_run(40);
        for (int k = 0; k < 4; k++) begin
            wv = rnd();
            m_div0 = wv & clkgen_pkg::MASK_DIV0;
            wr(clkgen_pkg::OFF_DIV0, wv);
            rdchk("div0", clkgen_pkg::OFF_DIV0, m_div0);
            wv = rnd();
            m_div1 = wv & clkgen_pkg::MASK_DIV1;
            wr(clkgen_pkg::OFF_DIV1, wv);
            rdchk("div1", clkgen_pkg::OFF_DIV1, m_div1);
            wv = rnd();
            wv[15:14] = k[1:0];
            m_pll = wv & clkgen_pkg::MASK_PLL;
            wr(clkgen_pkg::OFF_PLL, wv);
            #1;
            chk("pins", pll_pins, m_pll[18:0]);
            rdchk("pll", clkgen_pkg::OFF_PLL, m_pll);
            wr(clkgen_pkg::OFF_RATIO, wv);
            rdchk("ratio", clkgen_pkg::OFF_RATIO, rat(m_pll));
            rdchk("unmapped", 8'h1C, 32'h0);
            tick_run(300);
        end
        for (int k = 0; k < 16; k++) begin
            m_pll[18:17] = k[3:2];
            wr(clkgen_pkg::OFF_PLL, m_pll);
            xtal_clk <= k[0];
            pll_raw_clk <= k[1];
            @(posedge clock);
            #1;
            chk("clk_out", pll_clk_out, k[3] ? 0 : k[2] ? k[0] : k[1]);
            chk("ref_clk", pll_ref_clk, k[0]);
        end
        // A second reset in mid-run must bring every register back.
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        m_div0 = '0;
        m_div1 = '0;
        rst_n <= 1'b1;
        @(posedge clock);
        check_reset();
        tick_run(40);
        print_verdict();
    end
endmodule
